// ===== logic/tlc_limit_regs.v
// temperature limit registers, comparators and alert pin control
// assumes a register port driven by a two-wire slave on i_clk and a
// converter that presents a sample with a strobe from its own clock
//
// Behaviour
// - limits and temperature are two's complement
// - bit 2 weighs a quarter degree
// - finer resolution only in temperature data
// - comparisons use temperature bits 12..2 only
// - codes 10 and 11 show 12/13 bits
// - limit sign bit 12, unused bits, reset zero
// - alert on high limit crossings both ways
// - alert on low limit crossings both ways
// - window lock makes high/low read-only
// - critical alert held until below hysteresis
// - critical lock makes critical limit read-only
// - bit 15 critical flag with hysteresis
// - bit 14 high flag with hysteresis
// - bit 13 low flag with hysteresis
// - data bits finer than resolution read zero
// - read-only maker identifier register
// - part id upper byte, revision lower
// - resolution bits 4:3, reset 0018
// - resolution mirrored into capabilities
// - hysteresis codes give 0/1.5/3/6 degrees
// - alert comparator or latched interrupt mode
// - critical-only mode ignores window limits
`timescale 1ns/100ps
`include "tlc_map.vh"
module tlc_limit_regs #(
   parameter [15:0] MAKER_ID = 16'h1234, // arbitrary value
   parameter [7:0] PART_ID = 8'h5a, // arbitrary value
   parameter [7:0] REV_ID = 8'h01 // arbitrary value
) (
   input wire i_clk,
   input wire i_rst,
   input wire i_ce,
   input wire [3:0] i_reg_ptr,
   input wire i_wr_stb,
   input wire [15:0] i_wr_data,
   output wire [15:0] o_rd_data,
   input wire i_sample_clk,
   input wire [12:0] i_sample_data,
   input wire i_event_in,
   output wire o_event_out,
   output wire o_event_oe,
   output wire o_event_sts
);
   // limit registers hold only bits 12..2
   reg [15:0] high_limit_r;
   reg [15:0] low_limit_r;
   reg [15:0] crit_limit_r;
   reg [1:0] res_sel_r; // resolution_select
   // configuration fields
   reg [1:0] hysteresis_select_sel_r; // hysteresis_select
   reg shdn_r;
   reg crit_lock_r; // critical_limit_lock
   reg win_lock_r;
   reg ev_ctrl_r;
   reg crit_only_r; // critical_only_select
   reg ev_pol_r;
   reg ev_mode_r;
   // measurement and status
   reg [12:0] temp_r;
   reg crit_flag_r;
   reg high_flag_r;
   reg low_flag_r;
   reg int_latch_r;
   reg [15:0] rd_data_r;
   // synchronisers for the converter side
   reg samp_clk_s1_r;
   reg samp_clk_s2_r;
   reg samp_clk_s3_r;
   reg [12:0] samp_d_s1_r;
   reg [12:0] samp_d_s2_r;

   wire lock_any; // either lock bit set
   wire wr_cfg; // configuration write this cycle
   wire new_sample; // rising edge of the sample strobe
   wire [15:0] limit_wr; // write data with unused bits forced low
   wire signed [11:0] temp_cmp; // sample as compared
   wire signed [11:0] hysteresis_select_q; // hysteresis in quarter degrees
   wire crit_nxt;
   wire high_nxt;
   wire low_nxt;
   wire window_evt; // high or low flag changed
   wire crit_evt; // critical flag rose
   wire cmp_assert; // comparator-mode alert level
   wire ev_active; // alert asserted
   wire [15:0] temp_word;
   wire [15:0] cfg_word;

   // limit value as signed 12-bit compare operand
   function signed [11:0] lim_cmp;
      input [15:0] lim;
      begin
         lim_cmp = {lim[`TLC_CMP_HI], lim[`TLC_CMP_HI:`TLC_CMP_LO]};
      end
   endfunction

   // mask of visible temperature bits per resolution code
   function [12:0] res_mask;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: res_mask = `TLC_RMASK_0;
            2'h1: res_mask = `TLC_RMASK_1;
            2'h2: res_mask = `TLC_RMASK_2;
            default: res_mask = `TLC_RMASK_3;
         endcase
      end
   endfunction

   assign lock_any = crit_lock_r | win_lock_r;
   assign wr_cfg = i_wr_stb && (i_reg_ptr == `TLC_PTR_CONFIG);
   assign limit_wr = i_wr_data & `TLC_LIMIT_MASK;
   assign new_sample = samp_clk_s2_r & ~samp_clk_s3_r & ~shdn_r;

   // compare only the quarter-degree part of the sample
   assign temp_cmp = {samp_d_s2_r[`TLC_CMP_HI], samp_d_s2_r[`TLC_CMP_HI:`TLC_CMP_LO]};

   // hysteresis decode
   assign hysteresis_select_q = (hysteresis_select_sel_r == 2'h0) ? `TLC_HYSTERESIS_SELECT_0 :
                   (hysteresis_select_sel_r == 2'h1) ? `TLC_HYSTERESIS_SELECT_1 :
                   (hysteresis_select_sel_r == 2'h2) ? `TLC_HYSTERESIS_SELECT_2 : `TLC_HYSTERESIS_SELECT_3;

   // critical comparator
   tlc_hysteresis_select_cmp u_cmp_crit (
      .i_temp(temp_cmp),
      .i_limit(lim_cmp(crit_limit_r)),
      .i_hysteresis_select(hysteresis_select_q),
      .i_flag(crit_flag_r),
      .i_is_low(1'b0),
      .o_flag_nxt(crit_nxt)
   );

   // high limit comparator
   tlc_hysteresis_select_cmp u_cmp_high (
      .i_temp(temp_cmp),
      .i_limit(lim_cmp(high_limit_r)),
      .i_hysteresis_select(hysteresis_select_q),
      .i_flag(high_flag_r),
      .i_is_low(1'b0),
      .o_flag_nxt(high_nxt)
   );

   // low limit comparator
   tlc_hysteresis_select_cmp u_cmp_low (
      .i_temp(temp_cmp),
      .i_limit(lim_cmp(low_limit_r)),
      .i_hysteresis_select(hysteresis_select_q),
      .i_flag(low_flag_r),
      .i_is_low(1'b1),
      .o_flag_nxt(low_nxt)
   );

   // events for interrupt mode: any window crossing, critical entry
   assign window_evt = ~crit_only_r & ((high_nxt ^ high_flag_r) | (low_nxt ^ low_flag_r));
   assign crit_evt = crit_nxt & ~crit_flag_r;

   // comparator level, critical held through hysteresis
   assign cmp_assert = crit_flag_r | (~crit_only_r & (high_flag_r | low_flag_r));

   // alert asserted when enabled, never during shutdown
   assign ev_active = ev_ctrl_r & ~shdn_r &
                      (ev_mode_r ? (int_latch_r | crit_flag_r) : cmp_assert);

   // open drain: drive low when the pin level should be low
   assign o_event_out = 1'b0;
   assign o_event_oe = ev_pol_r ? ~ev_active : ev_active;
   assign o_event_sts = ev_active;

   // temperature word with flags and resolution masking
   assign temp_word = {crit_flag_r, high_flag_r, low_flag_r, temp_r & res_mask(res_sel_r)};

   // configuration word, clear bit reads zero
   assign cfg_word = {5'h00, hysteresis_select_sel_r, shdn_r, crit_lock_r, win_lock_r, 1'b0,
                      ev_active, ev_ctrl_r, crit_only_r, ev_pol_r, ev_mode_r};

   // pin synchronisers, two stages before use, third for the edge
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         samp_clk_s1_r <= 1'b0;
         samp_clk_s2_r <= 1'b0;
         samp_clk_s3_r <= 1'b0;
         samp_d_s1_r <= 13'h0000;
         samp_d_s2_r <= 13'h0000;
      end else if (i_ce) begin
         samp_clk_s1_r <= i_sample_clk;
         samp_clk_s2_r <= samp_clk_s1_r;
         samp_clk_s3_r <= samp_clk_s2_r;
         samp_d_s1_r <= i_sample_data;
         samp_d_s2_r <= samp_d_s1_r;
      end
   end

   // limit registers with lock protection, resolution register writable under any lock
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         high_limit_r <= `TLC_LIMIT_RST;
         low_limit_r <= `TLC_LIMIT_RST;
         crit_limit_r <= `TLC_LIMIT_RST;
         res_sel_r <= `TLC_RES_RST;
      end else if (i_ce && i_wr_stb) begin
         case (i_reg_ptr)
            `TLC_PTR_HIGH: begin
               if (!win_lock_r) begin
                  high_limit_r <= limit_wr;
               end
            end
            `TLC_PTR_LOW: begin
               if (!win_lock_r) begin
                  low_limit_r <= limit_wr;
               end
            end
            `TLC_PTR_CRIT: begin
               if (!crit_lock_r) begin
                  crit_limit_r <= limit_wr;
               end
            end
            `TLC_PTR_RES: begin
               res_sel_r <= i_wr_data[`TLC_RES_HI:`TLC_RES_LO];
            end
            default: begin
               res_sel_r <= res_sel_r; // other pointers store nothing here
            end
         endcase
      end
   end

   // configuration register, lock bits sticky until reset
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         hysteresis_select_sel_r <= 2'h0;
         shdn_r <= 1'b0;
         crit_lock_r <= 1'b0;
         win_lock_r <= 1'b0;
         ev_ctrl_r <= 1'b0;
         crit_only_r <= 1'b0;
         ev_pol_r <= 1'b0;
         ev_mode_r <= 1'b0;
      end else if (i_ce && wr_cfg) begin
         crit_lock_r <= crit_lock_r | i_wr_data[`TLC_CFG_CLOCK];
         win_lock_r <= win_lock_r | i_wr_data[`TLC_CFG_ELOCK];
         // shutdown may always be cleared, set only when unlocked
         if (!lock_any || !i_wr_data[`TLC_CFG_SHDN]) begin
            shdn_r <= i_wr_data[`TLC_CFG_SHDN];
         end
         // fields frozen by either lock
         if (!lock_any) begin
            hysteresis_select_sel_r <= i_wr_data[`TLC_CFG_HYSTERESIS_SELECT_HI:`TLC_CFG_HYSTERESIS_SELECT_LO];
            ev_ctrl_r <= i_wr_data[`TLC_CFG_CTRL];
            ev_pol_r <= i_wr_data[`TLC_CFG_POL];
            ev_mode_r <= i_wr_data[`TLC_CFG_MODE];
         end
         // critical-only frozen by the window lock
         if (!win_lock_r) begin
            crit_only_r <= i_wr_data[`TLC_CFG_CONLY];
         end
      end
   end

   // sample capture and flag update on each new sample
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         temp_r <= 13'h0000;
         crit_flag_r <= 1'b0;
         high_flag_r <= 1'b0;
         low_flag_r <= 1'b0;
      end else if (i_ce && new_sample) begin
         temp_r <= samp_d_s2_r;
         crit_flag_r <= crit_nxt;
         high_flag_r <= high_nxt;
         low_flag_r <= low_nxt;
      end
   end

   // interrupt latch: event set wins over a clear in the same cycle
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         int_latch_r <= 1'b0;
      end else if (i_ce) begin
         if (new_sample && ev_mode_r && (window_evt || crit_evt)) begin
            int_latch_r <= 1'b1;
         end else if (wr_cfg && i_wr_data[`TLC_CFG_CLEAR]) begin
            int_latch_r <= 1'b0;
         end
      end
   end

   // read data register for the currently addressed pointer
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rd_data_r <= 16'h0000;
      end else if (i_ce) begin
         case (i_reg_ptr)
            `TLC_PTR_CAPS: rd_data_r <= {8'h00, `TLC_CAPS_UPPER, res_sel_r, `TLC_CAPS_LOWER};
            `TLC_PTR_CONFIG: rd_data_r <= cfg_word;
            `TLC_PTR_HIGH: rd_data_r <= high_limit_r;
            `TLC_PTR_LOW: rd_data_r <= low_limit_r;
            `TLC_PTR_CRIT: rd_data_r <= crit_limit_r;
            `TLC_PTR_TEMP: rd_data_r <= temp_word;
            `TLC_PTR_MAKER: rd_data_r <= MAKER_ID;
            `TLC_PTR_PART: rd_data_r <= {PART_ID, REV_ID};
            `TLC_PTR_RES: rd_data_r <= {11'h000, res_sel_r, 3'h0};
            default: rd_data_r <= 16'h0000; // unmapped pointers read zero
         endcase
      end
   end

   assign o_rd_data = rd_data_r;
endmodule

// ===== common/tlc_map.vh
// register pointers, field positions, reset values and coding constants
// assumes it is included by bare name from the temperature limit logic
`ifndef TLC_MAP_VH
`define TLC_MAP_VH

// register pointer values
`define TLC_PTR_CAPS 4'h0
`define TLC_PTR_CONFIG 4'h1
`define TLC_PTR_HIGH 4'h2
`define TLC_PTR_LOW 4'h3
`define TLC_PTR_CRIT 4'h4
`define TLC_PTR_TEMP 4'h5
`define TLC_PTR_MAKER 4'h6
`define TLC_PTR_PART 4'h7
`define TLC_PTR_RES 4'h8

// reset values
`define TLC_LIMIT_RST 16'h0000
`define TLC_CONFIG_RST 16'h0000
`define TLC_RES_RST 2'h3

// limit word layout: sign at 12, quarter degree at 2
`define TLC_LIMIT_MASK 16'h1ffc
`define TLC_CMP_HI 12
`define TLC_CMP_LO 2

// temperature word status bits
`define TLC_TEMP_CRIT 15
`define TLC_TEMP_HIGH 14
`define TLC_TEMP_LOW 13

// resolution field position in resolution and capability words
`define TLC_RES_LO 3
`define TLC_RES_HI 4

// fixed capability bits around the resolution field
`define TLC_CAPS_UPPER 3'h7
`define TLC_CAPS_LOWER 3'h7

// configuration bit positions
`define TLC_CFG_HYSTERESIS_SELECT_LO 9
`define TLC_CFG_HYSTERESIS_SELECT_HI 10
`define TLC_CFG_SHDN 8
`define TLC_CFG_CLOCK 7
`define TLC_CFG_ELOCK 6
`define TLC_CFG_CLEAR 5
`define TLC_CFG_STS 4
`define TLC_CFG_CTRL 3
`define TLC_CFG_CONLY 2
`define TLC_CFG_POL 1
`define TLC_CFG_MODE 0

// hysteresis in quarter degrees: 0, 1.5, 3, 6 degrees
`define TLC_HYSTERESIS_SELECT_0 12'h000
`define TLC_HYSTERESIS_SELECT_1 12'h006
`define TLC_HYSTERESIS_SELECT_2 12'h00c
`define TLC_HYSTERESIS_SELECT_3 12'h018

// resolution masks on temperature bits 12..0
`define TLC_RMASK_0 13'h1ff8
`define TLC_RMASK_1 13'h1ffc
`define TLC_RMASK_2 13'h1ffe
`define TLC_RMASK_3 13'h1fff

`endif

// ===== logic/tlc_hysteresis_select_cmp.v
// one limit comparator with hysteresis, giving the next flag value
// assumes signed 12-bit inputs in quarter degrees, sign-extended
`timescale 1ns/100ps
module tlc_hysteresis_select_cmp (
   input wire signed [11:0] i_temp,
   input wire signed [11:0] i_limit,
   input wire signed [11:0] i_hysteresis_select,
   input wire i_flag,
   input wire i_is_low,
   output wire o_flag_nxt
);
   wire signed [11:0] lim_minus_hysteresis_select; // lowered threshold
   wire above_set; // upper limit crossed upward
   wire above_clr; // upper limit released on the way down
   wire below_set; // lower limit crossed downward
   wire below_clr; // lower limit met again
   assign lim_minus_hysteresis_select = i_limit - i_hysteresis_select;
   assign above_set = i_temp > i_limit;
   assign above_clr = i_temp <= lim_minus_hysteresis_select;
   assign below_set = i_temp < lim_minus_hysteresis_select;
   assign below_clr = i_temp >= i_limit;
   // set has priority, otherwise clear, otherwise hold
   assign o_flag_nxt = i_is_low ? (below_set | (i_flag & ~below_clr)) :
                                  (above_set | (i_flag & ~above_clr));
endmodule

// ===== test/tlc_limit_regs_monitor.sv
// concurrent checks on the limit register block ports
// assumes one i_clk domain and binding onto tlc_limit_regs
`timescale 1ns/100ps
module tlc_limit_regs_monitor #(
   parameter [15:0] MAKER_ID = 16'h1234, // arbitrary value
   parameter [7:0] PART_ID = 8'h5a, // arbitrary value
   parameter [7:0] REV_ID = 8'h01 // arbitrary value
) (
   input wire i_clk,
   input wire i_rst,
   input wire i_ce,
   input wire [3:0] i_reg_ptr,
   input wire i_wr_stb,
   input wire [15:0] i_wr_data,
   input wire [15:0] o_rd_data,
   input wire i_sample_clk,
   input wire [12:0] i_sample_data,
   input wire i_event_in,
   input wire o_event_out,
   input wire o_event_oe,
   input wire o_event_sts
);
   reg [7:0] hist_r; // recent strobe levels
   wire recent = |hist_r; // a sample may still be landing
   wire [1:0] rd_res = o_rd_data[4:3]; // resolution field as read
   // shift the strobe level in each clock
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst)
         hist_r <= 8'h00;
      else
         hist_r <= {hist_r[6:0], i_sample_clk};
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // resolution read directly followed by capabilities read
   sequence res_then_caps;
      i_ce && !i_wr_stb && i_reg_ptr == 4'h8 ##1 i_ce && !i_wr_stb && i_reg_ptr == 4'h0;
   endsequence
   // no write, no sample, pointer held
   sequence quiet;
      i_ce && !i_wr_stb && !recent && $stable(i_reg_ptr);
   endsequence
   maker_read_a: assert property (i_ce && i_reg_ptr == 4'h6 |=> o_rd_data == MAKER_ID)
      else $error("maker word wrong");
   part_read_a: assert property (i_ce && i_reg_ptr == 4'h7 |=> o_rd_data == {PART_ID, REV_ID})
      else $error("part word wrong");
   unmapped_zero_a: assert property (i_ce && i_reg_ptr > 4'h8 |=> o_rd_data == 16'h0000)
      else $error("unmapped read not zero");
   limit_unused_a: assert property (i_ce && i_reg_ptr inside {[4'h2:4'h4]} |=> (o_rd_data & 16'he003) == 16'h0000)
      else $error("limit unused bits set");
   res_field_a: assert property (i_ce && i_reg_ptr == 4'h8 |=> (o_rd_data & 16'hffe7) == 16'h0000)
      else $error("resolution word stray bits");
   caps_mirror_a: assert property (res_then_caps |=> o_rd_data == {8'h00, 3'h7, $past(rd_res), 3'h7})
      else $error("capabilities not mirroring resolution");
   pin_low_a: assert property (o_event_out == 1'b0)
      else $error("alert data not low");
   reset_quiet_a: assert property ($fell(i_rst) |-> !o_event_sts && !o_event_oe)
      else $error("alert active after reset");
   alert_cause_a: assert property ($changed({o_event_sts, o_event_oe}) |-> $past(i_wr_stb) || recent)
      else $error("alert moved without cause");
   rd_hold_a: assert property (quiet [*3] |=> $stable(o_rd_data))
      else $error("read data moved while idle");
endmodule
bind tlc_limit_regs tlc_limit_regs_monitor #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID), .REV_ID(REV_ID))
   tlc_limit_regs_monitor_i (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_reg_ptr(i_reg_ptr),
   .i_wr_stb(i_wr_stb), .i_wr_data(i_wr_data), .o_rd_data(o_rd_data), .i_sample_clk(i_sample_clk),
   .i_sample_data(i_sample_data), .i_event_in(i_event_in), .o_event_out(o_event_out),
   .o_event_oe(o_event_oe), .o_event_sts(o_event_sts));

// ===== test/tlc_sensor_model.sv
// converter stand-in driving the sample strobe and word
// assumes one send call per sample; strobe idle between frames
`timescale 1ns/100ps
module tlc_sensor_model (
   output reg o_sample_clk,
   output reg [12:0] o_sample_data
);
   // strobe low and word idle at start
   initial begin
      o_sample_clk = 1'b0;
      o_sample_data = 13'h0000;
   end
   // one 145 ns frame, word held past the falling strobe
   task send(input [12:0] v);
      begin
         o_sample_data = v;
         #20;
         o_sample_clk = 1'b1;
         #62.5;
         o_sample_clk = 1'b0;
         #62.5;
         o_sample_data = ~v; // word no longer valid
      end
   endtask
endmodule

// ===== test/tlc_limit_regs_bench.sv
// self-checking bench for the limit register block
// assumes the monitor binds itself and the sensor model feeds samples
`timescale 1ns/100ps
module tlc_limit_regs_bench;
   localparam [15:0] MAKER = 16'h3c5a; // arbitrary value
   localparam [7:0] PART = 8'h6b; // arbitrary value
   localparam [7:0] REV = 8'h02; // arbitrary value
   reg i_clk; // system clock
   reg i_rst; // async reset
   reg i_ce; // clock enable
   reg [3:0] ptr; // register pointer
   reg stb; // write strobe
   reg [15:0] wdata; // write data
   wire [15:0] rd; // read data
   wire sclk; // sample strobe
   wire [12:0] sdata; // sample word
   wire ev_out; // alert data value
   wire ev_oe; // alert pull enable
   wire ev_sts; // alert status
   wire ev_wire = ev_oe ? ev_out : 1'b1; // pulled-up shared line
   integer err_total; // mismatches
   integer compares; // comparisons made
   integer c; // loop index
   reg [12:0] h; // hysteresis in sixteenths
   tlc_limit_regs #(.MAKER_ID(MAKER), .PART_ID(PART), .REV_ID(REV)) tlc_limit_regs_i (
      .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_reg_ptr(ptr), .i_wr_stb(stb),
      .i_wr_data(wdata), .o_rd_data(rd), .i_sample_clk(sclk), .i_sample_data(sdata),
      .i_event_in(ev_wire), .o_event_out(ev_out), .o_event_oe(ev_oe), .o_event_sts(ev_sts));
   tlc_sensor_model tlc_sensor_model_i (.o_sample_clk(sclk), .o_sample_data(sdata));
   // 100 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // word compare
   task chk16(input string nm, input [15:0] e, input [15:0] g);
      begin
         compares = compares + 1;
         if (g !== e) begin
            err_total = err_total + 1;
            $display("BAD %s exp %h got %h", nm, e, g);
         end
      end
   endtask
   // single bit compare
   task chk1(input string nm, input e, input g);
      chk16(nm, {15'h0000, e}, {15'h0000, g});
   endtask
   // one register write
   task wr(input [3:0] p, input [15:0] d);
      begin
         @(negedge i_clk);
         ptr = p;
         stb = 1'b1;
         wdata = d;
         @(negedge i_clk);
         stb = 1'b0;
      end
   endtask
   // read one register and compare
   task rd_chk(input string nm, input [3:0] p, input [15:0] e);
      begin
         @(negedge i_clk);
         ptr = p;
         @(negedge i_clk);
         chk16(nm, e, rd);
      end
   endtask
   // send a sample, check word and active-low alert
   task step(input [12:0] v, input [15:0] e, input a);
      begin
         tlc_sensor_model_i.send(v);
         rd_chk("temp", 4'h5, e);
         chk1("alert sts", a, ev_sts);
         chk1("alert wire", ~a, ev_wire);
      end
   endtask
   // verdict and end of run
   task final_report;
      begin
         $display("errors %0d compares %0d", err_total, compares);
         if (err_total == 0 && compares > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   // hang guard
   initial begin
      #200000;
      err_total = err_total + 1;
      final_report;
   end
   // main sequence
   initial begin
      err_total = 0;
      compares = 0;
      i_rst = 1'b1;
      i_ce = 1'b1;
      ptr = 4'h0;
      stb = 1'b0;
      wdata = 16'h0000;
      repeat (4) @(negedge i_clk);
      i_rst = 1'b0;
      repeat (4) @(negedge i_clk);
      rd_chk("caps", 4'h0, 16'h00ff);
      rd_chk("config", 4'h1, 16'h0000);
      rd_chk("crit", 4'h4, 16'h0000);
      rd_chk("maker", 4'h6, MAKER);
      rd_chk("part", 4'h7, {PART, REV});
      rd_chk("res", 4'h8, 16'h0018);
      rd_chk("unmapped", 4'h9, 16'h0000);
      wr(4'h2, 16'hffff);
      rd_chk("high", 4'h2, 16'h1ffc);
      wr(4'h2, 16'h0190);
      wr(4'h3, 16'h00a0);
      wr(4'h4, 16'h0280);
      wr(4'h1, 16'h0208);
      step(13'h0140, 16'h0140, 1'b0);
      step(13'h0191, 16'h0191, 1'b0);
      // each hysteresis code: set, hold a quarter above, clear at threshold
      for (c = 0; c < 4; c = c + 1) begin
         h = (c == 0) ? 13'h0000 : (13'h0018 << (c - 1));
         wr(4'h1, {5'h00, c[1:0], 9'h008});
         step(13'h0194, 16'h4194, 1'b1);
         step(13'h0194 - h, {3'h2, 13'h0194 - h}, 1'b1);
         step(13'h0190 - h, {3'h0, 13'h0190 - h}, 1'b0);
      end
      wr(4'h1, 16'h0208);
      step(13'h0090, 16'h0090, 1'b0);
      step(13'h0084, 16'h2084, 1'b1);
      step(13'h009c, 16'h209c, 1'b1);
      step(13'h00a0, 16'h00a0, 1'b0);
      step(13'h0284, 16'hc284, 1'b1);
      step(13'h0268, 16'h4268, 1'b1);
      step(13'h1fd4, 16'h3fd4, 1'b1);
      step(13'h0147, 16'h0147, 1'b0);
      // each resolution code on one stored sample
      for (c = 0; c < 4; c = c + 1) begin
         wr(4'h8, {11'h000, c[1:0], 3'h0});
         rd_chk("res", 4'h8, {11'h000, c[1:0], 3'h0});
         rd_chk("caps", 4'h0, {8'h00, 3'h7, c[1:0], 3'h7});
         rd_chk("temp", 4'h5, {3'h0, 13'h0147 & (13'h1fff << (3 - c))});
         rd_chk("high", 4'h2, 16'h0190);
      end
      wr(4'h1, 16'h020c);
      step(13'h0194, 16'h4194, 1'b0);
      step(13'h0284, 16'hc284, 1'b1);
      step(13'h0140, 16'h0140, 1'b0);
      // active-high polarity: asserted releases the pulled-up wire
      wr(4'h1, 16'h020a);
      tlc_sensor_model_i.send(13'h0194);
      rd_chk("temp", 4'h5, 16'h4194);
      chk1("alert wire hi", 1'b1, ev_wire);
      tlc_sensor_model_i.send(13'h0140);
      rd_chk("temp", 4'h5, 16'h0140);
      chk1("alert wire lo", 1'b0, ev_wire);
      wr(4'h1, 16'h0229);
      step(13'h0194, 16'h4194, 1'b1);
      step(13'h0140, 16'h0140, 1'b1);
      wr(4'h1, 16'h0229);
      step(13'h0140, 16'h0140, 1'b0);
      rd_chk("config", 4'h1, 16'h0209);
      // shutdown drops samples and keeps the alert released
      wr(4'h1, 16'h0308);
      step(13'h0194, 16'h0140, 1'b0);
      rd_chk("config", 4'h1, 16'h0308);
      // clock enable low freezes the registers
      i_ce = 1'b0;
      wr(4'h2, 16'h0100);
      i_ce = 1'b1;
      rd_chk("high", 4'h2, 16'h0190);
      wr(4'h1, 16'h02c9);
      for (c = 2; c < 5; c = c + 1)
         wr(c[3:0], 16'h0300);
      rd_chk("high", 4'h2, 16'h0190);
      rd_chk("low", 4'h3, 16'h00a0);
      rd_chk("crit", 4'h4, 16'h0280);
      i_rst = 1'b1;
      repeat (2) @(negedge i_clk);
      i_rst = 1'b0;
      rd_chk("high", 4'h2, 16'h0000);
      final_report;
   end
endmodule
